// *** hw/rbm_consts.vh ***
// Constants for the radio burst mode and status logic
`ifndef RBM_CONSTS_VH
`define RBM_CONSTS_VH
// Clock and link timing
`define RBM_CLK_MHZ        200
`define RBM_CHIP_KBPS      100
`define RBM_CHIP_CYC       ((`RBM_CLK_MHZ * 1000) / `RBM_CHIP_KBPS)
`define RBM_CHIP_LAST      (`RBM_CHIP_CYC - 1)
`define RBM_RX_SETTLE_US   650
`define RBM_RX_SETTLE_CYC  (`RBM_RX_SETTLE_US * `RBM_CLK_MHZ)
// Register byte offsets
`define RBM_OFF_CONFIG     8'h00
`define RBM_OFF_MODE       8'h04
`define RBM_OFF_RX_ADDR    8'h08
`define RBM_OFF_STATUS     8'h0c
`define RBM_OFF_TX_DATA    8'h10
`define RBM_OFF_RX_DATA    8'h14
`define RBM_OFF_FREQ       8'h18
`define RBM_OFF_PA_DBM     8'h1c
`define RBM_OFF_TX_ADDR    8'h20
`define RBM_OFF_BUF_CTRL   8'h24
// Configuration word fields
`define RBM_CFG_CH_MSB     8
`define RBM_CFG_CH_LSB     0
`define RBM_CFG_BAND_BIT   9
`define RBM_CFG_PWR_MSB    11
`define RBM_CFG_PWR_LSB    10
`define RBM_CFG_LOWPWR_BIT 12
`define RBM_CFG_REPEAT_BIT 13
`define RBM_CFG_RST        14'h006c
// Mode and buffer control fields
`define RBM_MODE_CE_BIT    0
`define RBM_MODE_TX_BIT    1
`define RBM_MODE_RST       2'h0
`define RBM_BUF_CLR_BIT    0
// Frequency base in 100 kHz units
`define RBM_FREQ_BASE      14'h1080
// Transmit levels in dBm, two's complement
`define RBM_DBM_PWR0       8'hf6
`define RBM_DBM_PWR1       8'hfe
`define RBM_DBM_PWR2       8'h06
`define RBM_DBM_PWR3       8'h0a
// Packet framing
`define RBM_PRE_PATTERN    10'h2aa
`define RBM_PRE_LAST       4'h9
`define RBM_ADDR_BYTES     6'h04
`define RBM_HDR_BYTES      6'h05
`define RBM_MAX_PAYLOAD    6'h20
`define RBM_ADDR_RST       32'h0000_0000
`endif

// *** hw/rbm_buf.v ***
// Payload byte buffer with registered read port
`timescale 1ns/1ps
`default_nettype none
module rbm_buf (
	// Clock and reset
	input  wire       pclk,
	input  wire       presetn,
	// Write port
	input  wire       wr_en,
	input  wire [4:0] wr_addr,
	input  wire [7:0] wr_data,
	// Read port
	input  wire [4:0] rd_addr,
	output reg  [7:0] rd_data_ff
);
	reg [7:0] mem [0:31];

	always @(posedge pclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_data_ff <= 8'h00;
		end else begin
			rd_data_ff <= mem[rd_addr];
		end
	end
endmodule // rbm_buf
`default_nettype wire

// *** hw/rbm_manch.v ***
// Chip-rate divider with Manchester encoder and decoder
`timescale 1ns/1ps
`default_nettype none
`include "rbm_consts.vh"
module rbm_manch (
	// Clock and reset
	input  wire pclk,
	input  wire presetn,
	// Transmit side
	input  wire tx_active,
	input  wire tx_bit,
	output reg  bit_tick_ff,
	output reg  tx_chip_ff,
	// Receive side
	input  wire rx_chip,
	output reg  rx_valid_ff,
	output reg  rx_bit_ff
);
	reg  [10:0] div_ff;
	reg         tx_phase_ff;
	reg         chip_d1_ff;
	reg         chip_d2_ff;
	reg         rx_phase_ff;
	reg         rx_first_ff;
	wire        chip_tick;

	assign chip_tick = ({21'h0, div_ff} == `RBM_CHIP_LAST);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_ff      <= 11'h000;
			tx_phase_ff <= 1'b0;
			bit_tick_ff <= 1'b0;
			chip_d1_ff  <= 1'b0;
			chip_d2_ff  <= 1'b0;
			tx_chip_ff  <= 1'b0;
			rx_phase_ff <= 1'b0;
			rx_first_ff <= 1'b0;
			rx_valid_ff <= 1'b0;
			rx_bit_ff   <= 1'b0;
		end else begin
			div_ff      <= chip_tick ? 11'h000 : div_ff + 11'h001;
			bit_tick_ff <= chip_tick & tx_phase_ff;
			chip_d1_ff  <= chip_tick;
			chip_d2_ff  <= chip_d1_ff;
			rx_valid_ff <= 1'b0;
			if (chip_tick) begin
				tx_phase_ff <= ~tx_phase_ff;
			end
			if (chip_d2_ff) begin
				tx_chip_ff <= tx_active & (tx_bit ^ tx_phase_ff);
			end
			if (chip_tick) begin
				if (!rx_phase_ff) begin
					rx_first_ff <= rx_chip;
					rx_phase_ff <= 1'b1;
				end else if (rx_chip != rx_first_ff) begin
					rx_valid_ff <= 1'b1;
					rx_bit_ff   <= rx_first_ff;
					rx_phase_ff <= 1'b0;
				end else begin
					// Equal chips: slip one chip to realign
					rx_first_ff <= rx_chip;
				end
			end
		end
	end
endmodule // rbm_manch
`default_nettype wire

// *** hw/rbm_top.v ***
// Burst mode, status flags and APB registers of the packet radio
`timescale 1ns/1ps
`default_nettype none
`include "rbm_consts.vh"
module rbm_top #(
	parameter [17:0] SETTLE_CYC = `RBM_RX_SETTLE_CYC
) (
	// Clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata_ff,
	output reg         pready_ff,
	output reg         pslverr_ff,
	// Radio front end
	input  wire        rf_rx_chip,
	input  wire        rf_carrier_in,
	output wire        rf_tx_chip,
	output reg  [1:0]  pa_level_ff,
	output reg         rx_low_power_ff,
	output reg  [13:0] freq_code_ff,
	// Status flags to the controller
	output reg         carrier_sensed_flag_ff,
	output reg         address_hit_flag_ff,
	output reg         packet_done_flag_ff
);
	localparam [2:0] ST_STBY   = 3'h0;
	localparam [2:0] ST_RXSET  = 3'h1;
	localparam [2:0] ST_RXHUNT = 3'h2;
	localparam [2:0] ST_RXPKT  = 3'h3;
	localparam [2:0] ST_TXRUN  = 3'h4;
	localparam [2:0] ST_TXDONE = 3'h5;

	reg  [2:0]  state_ff,    nxt_state;
	reg  [13:0] cfg_ff,      nxt_cfg;
	reg  [1:0]  mode_ff,     nxt_mode;
	reg  [31:0] rx_addr_ff,  nxt_rx_addr;
	reg  [31:0] tx_addr_ff,  nxt_tx_addr;
	reg  [5:0]  tx_len_ff,   nxt_tx_len;
	reg  [17:0] settle_ff,   nxt_settle;
	reg  [9:0]  tx_sh_ff,    nxt_tx_sh;
	reg  [3:0]  tx_bits_ff,  nxt_tx_bits;
	reg  [5:0]  tx_idx_ff,   nxt_tx_idx;
	reg         tx_pre_ff,   nxt_tx_pre;
	reg  [7:0]  tx_sum_ff,   nxt_tx_sum;
	reg  [31:0] rx_sh_ff,    nxt_rx_sh;
	reg  [2:0]  rx_bits_ff,  nxt_rx_bits;
	reg  [5:0]  rx_idx_ff,   nxt_rx_idx;
	reg  [5:0]  rx_plen_ff,  nxt_rx_plen;
	reg  [5:0]  rx_len_ff,   nxt_rx_len;
	reg  [5:0]  rd_ptr_ff,   nxt_rd_ptr;
	reg  [7:0]  rx_sum_ff,   nxt_rx_sum;
	reg         am_ff,       nxt_am;
	reg         done_ff,     nxt_done;
	reg  [31:0] nxt_prdata;
	reg         nxt_pready;
	reg         nxt_pslverr;
	reg  [31:0] rd_val;
	reg         addr_ok;
	reg         start_tx;
	reg  [7:0]  tx_byte;
	reg  [7:0]  rx_byte;
	reg         rx_wen;
	reg  [7:0]  dbm;
	wire        ce;
	wire        txs;
	wire        stby;
	wire        acc_first;
	wire        xfer_done;
	wire        wr_ok;
	wire        rd_ok;
	wire [5:0]  ld_idx;
	wire [5:0]  tx_rd_addr;
	wire [5:0]  tx_last;
	wire [7:0]  tx_mem_q;
	wire [7:0]  rx_mem_q;
	wire        tx_wen;
	wire        bit_tick;
	wire        rx_valid;
	wire        rx_bit;
	wire        repeat_on;

	assign ce         = mode_ff[`RBM_MODE_CE_BIT];
	assign txs        = mode_ff[`RBM_MODE_TX_BIT];
	assign stby       = (state_ff == ST_STBY);
	assign repeat_on  = cfg_ff[`RBM_CFG_REPEAT_BIT];
	assign acc_first  = psel & penable & ~pready_ff;
	assign xfer_done  = psel & penable & pready_ff;
	assign wr_ok      = xfer_done & pwrite & addr_ok;
	assign rd_ok      = xfer_done & ~pwrite & addr_ok;
	assign ld_idx     = tx_pre_ff ? 6'h00 : tx_idx_ff + 6'h01;
	assign tx_rd_addr = ld_idx - `RBM_HDR_BYTES;
	assign tx_last    = `RBM_HDR_BYTES + tx_len_ff;
	assign tx_wen     = wr_ok & stby & (paddr == `RBM_OFF_TX_DATA) & (tx_len_ff < `RBM_MAX_PAYLOAD);

	rbm_buf u_tx_buf (
		.pclk       (pclk),
		.presetn    (presetn),
		.wr_en      (tx_wen),
		.wr_addr    (tx_len_ff[4:0]),
		.wr_data    (pwdata[7:0]),
		.rd_addr    (tx_rd_addr[4:0]),
		.rd_data_ff (tx_mem_q)
	);

	rbm_buf u_rx_buf (
		.pclk       (pclk),
		.presetn    (presetn),
		.wr_en      (rx_wen),
		.wr_addr    (rx_idx_ff[4:0] - 5'h01),
		.wr_data    (rx_byte),
		.rd_addr    (rd_ptr_ff[4:0]),
		.rd_data_ff (rx_mem_q)
	);

	rbm_manch u_manch (
		.pclk        (pclk),
		.presetn     (presetn),
		.tx_active   (state_ff == ST_TXRUN),
		.tx_bit      (tx_sh_ff[9]),
		.bit_tick_ff (bit_tick),
		.tx_chip_ff  (rf_tx_chip),
		.rx_chip     (rf_rx_chip),
		.rx_valid_ff (rx_valid),
		.rx_bit_ff   (rx_bit)
	);

	always @* begin
		case (cfg_ff[`RBM_CFG_PWR_MSB:`RBM_CFG_PWR_LSB])
			2'h0: dbm = `RBM_DBM_PWR0;
			2'h1: dbm = `RBM_DBM_PWR1;
			2'h2: dbm = `RBM_DBM_PWR2;
			default: dbm = `RBM_DBM_PWR3;
		endcase
	end

	// Register read mux and address decode
	always @* begin
		rd_val  = 32'h0000_0000;
		addr_ok = 1'b1;
		if (paddr == `RBM_OFF_CONFIG) begin
			rd_val = {18'h0, cfg_ff};
		end else if (paddr == `RBM_OFF_MODE) begin
			rd_val = {30'h0, mode_ff};
		end else if (paddr == `RBM_OFF_RX_ADDR) begin
			rd_val = rx_addr_ff;
		end else if (paddr == `RBM_OFF_STATUS) begin
			rd_val = {19'h0, rx_len_ff, state_ff, 1'b0, done_ff, am_ff, carrier_sensed_flag_ff};
		end else if (paddr == `RBM_OFF_TX_DATA) begin
			rd_val = {26'h0, tx_len_ff};
		end else if (paddr == `RBM_OFF_RX_DATA) begin
			rd_val = {24'h0, rx_mem_q};
		end else if (paddr == `RBM_OFF_FREQ) begin
			rd_val = {18'h0, freq_code_ff};
		end else if (paddr == `RBM_OFF_PA_DBM) begin
			rd_val = {24'h0, dbm};
		end else if (paddr == `RBM_OFF_TX_ADDR) begin
			rd_val = tx_addr_ff;
		end else if (paddr == `RBM_OFF_BUF_CTRL) begin
			rd_val = 32'h0000_0000;
		end else begin
			addr_ok = 1'b0;
		end
	end

	// Next byte to serialise
	always @* begin
		if (ld_idx < `RBM_ADDR_BYTES) begin
			case (ld_idx[1:0])
				2'h0: tx_byte = tx_addr_ff[31:24];
				2'h1: tx_byte = tx_addr_ff[23:16];
				2'h2: tx_byte = tx_addr_ff[15:8];
				default: tx_byte = tx_addr_ff[7:0];
			endcase
		end else if (ld_idx == `RBM_ADDR_BYTES) begin
			tx_byte = {2'h0, tx_len_ff};
		end else if (ld_idx < tx_last) begin
			tx_byte = tx_mem_q;
		end else begin
			tx_byte = tx_sum_ff;
		end
	end

	always @* begin
		nxt_state   = state_ff;
		nxt_cfg     = cfg_ff;
		nxt_mode    = mode_ff;
		nxt_rx_addr = rx_addr_ff;
		nxt_tx_addr = tx_addr_ff;
		nxt_tx_len  = tx_len_ff;
		nxt_settle  = settle_ff;
		nxt_tx_sh   = tx_sh_ff;
		nxt_tx_bits = tx_bits_ff;
		nxt_tx_idx  = tx_idx_ff;
		nxt_tx_pre  = tx_pre_ff;
		nxt_tx_sum  = tx_sum_ff;
		nxt_rx_sh   = rx_sh_ff;
		nxt_rx_bits = rx_bits_ff;
		nxt_rx_idx  = rx_idx_ff;
		nxt_rx_plen = rx_plen_ff;
		nxt_rx_len  = rx_len_ff;
		nxt_rd_ptr  = rd_ptr_ff;
		nxt_rx_sum  = rx_sum_ff;
		nxt_am      = am_ff;
		nxt_done    = done_ff;
		nxt_prdata  = prdata_ff;
		nxt_pready  = pready_ff;
		nxt_pslverr = pslverr_ff;
		start_tx    = 1'b0;
		rx_wen      = 1'b0;
		rx_byte     = {rx_sh_ff[6:0], rx_bit};
		// One wait state on every access
		if (acc_first) begin
			nxt_pready  = 1'b1;
			nxt_prdata  = rd_val;
			nxt_pslverr = ~addr_ok;
		end else if (xfer_done) begin
			nxt_pready  = 1'b0;
			nxt_pslverr = 1'b0;
		end
		if (wr_ok && paddr == `RBM_OFF_MODE) begin
			nxt_mode = pwdata[1:0];
		end
		if (wr_ok && stby) begin
			if (paddr == `RBM_OFF_CONFIG) begin
				nxt_cfg = pwdata[13:0];
			end else if (paddr == `RBM_OFF_RX_ADDR) begin
				nxt_rx_addr = pwdata;
			end else if (paddr == `RBM_OFF_TX_ADDR) begin
				nxt_tx_addr = pwdata;
			end else if (paddr == `RBM_OFF_TX_DATA && tx_wen) begin
				nxt_tx_len = tx_len_ff + 6'h01;
			end else if (paddr == `RBM_OFF_BUF_CTRL && pwdata[`RBM_BUF_CLR_BIT]) begin
				nxt_tx_len = 6'h00;
			end
		end
		if (rd_ok && paddr == `RBM_OFF_RX_DATA && rd_ptr_ff < rx_len_ff) begin
			nxt_rd_ptr = rd_ptr_ff + 6'h01;
			if (rd_ptr_ff + 6'h01 == rx_len_ff) begin
				nxt_done = 1'b0;
				nxt_am   = 1'b0;
			end
		end
		case (state_ff)
			ST_STBY: begin
				if (ce && txs) begin
					start_tx = 1'b1;
				end else if (ce) begin
					nxt_state  = ST_RXSET;
					nxt_settle = 18'h00000;
				end
			end
			ST_RXSET: begin
				if (!ce) begin
					nxt_state = ST_STBY;
				end else if (txs) begin
					start_tx = 1'b1;
				end else if (settle_ff == SETTLE_CYC - 18'h00001) begin
					nxt_state = ST_RXHUNT;
				end else begin
					nxt_settle = settle_ff + 18'h00001;
				end
			end
			ST_RXHUNT, ST_RXPKT: begin
				if (!ce) begin
					nxt_state = ST_STBY;
					nxt_am    = 1'b0;
				end else if (txs) begin
					start_tx  = 1'b1;
					nxt_am    = 1'b0;
				end else if (rx_valid && state_ff == ST_RXHUNT) begin
					nxt_rx_sh = {rx_sh_ff[30:0], rx_bit};
					if ({rx_sh_ff[30:0], rx_bit} == rx_addr_ff) begin
						nxt_state   = ST_RXPKT;
						nxt_am      = 1'b1;
						nxt_rx_bits = 3'h7;
						nxt_rx_idx  = 6'h00;
						nxt_rx_sum  = 8'h00;
					end
				end else if (rx_valid) begin
					nxt_rx_sh   = {rx_sh_ff[30:0], rx_bit};
					nxt_rx_bits = rx_bits_ff - 3'h1;
					if (rx_bits_ff == 3'h0) begin
						nxt_rx_idx = rx_idx_ff + 6'h01;
						nxt_rx_sum = rx_sum_ff + rx_byte;
						if (rx_idx_ff == 6'h00) begin
							nxt_rx_plen = rx_byte[5:0];
							if (rx_byte == 8'h00 || rx_byte > {2'h0, `RBM_MAX_PAYLOAD}) begin
								nxt_state = ST_RXHUNT;
								nxt_am    = 1'b0;
								nxt_rx_sh = 32'h0000_0000;
							end
						end else if (rx_idx_ff <= rx_plen_ff) begin
							rx_wen = 1'b1;
						end else begin
							nxt_state = ST_RXHUNT;
							nxt_rx_sh = 32'h0000_0000;
							if (rx_byte == rx_sum_ff) begin
								nxt_rx_len = rx_plen_ff;
								nxt_rd_ptr = 6'h00;
								nxt_done   = 1'b1;
							end else begin
								nxt_am = 1'b0;
							end
						end
					end
				end
			end
			ST_TXRUN: begin
				// mode lines only read at packet end
				if (bit_tick) begin
					if (tx_bits_ff != 4'h0) begin
						nxt_tx_sh   = {tx_sh_ff[8:0], 1'b0};
						nxt_tx_bits = tx_bits_ff - 4'h1;
					end else if (tx_pre_ff || tx_idx_ff != tx_last) begin
						if (tx_pre_ff && repeat_on) begin
							nxt_done = 1'b0;
						end
						nxt_tx_pre  = 1'b0;
						nxt_tx_idx  = ld_idx;
						nxt_tx_sh   = {tx_byte, 2'h0};
						nxt_tx_bits = 4'h7;
						if (ld_idx >= `RBM_ADDR_BYTES && ld_idx < tx_last) begin
							nxt_tx_sum = tx_sum_ff + tx_byte;
						end
					end else if (repeat_on && ce && txs) begin
						start_tx = 1'b1;
					end else if (!ce) begin
						nxt_state = ST_STBY;
						nxt_done  = 1'b0;
					end else if (!txs) begin
						nxt_state  = ST_RXSET;
						nxt_settle = 18'h00000;
						nxt_done   = 1'b0;
					end else begin
						nxt_state = ST_TXDONE;
						nxt_done  = ~repeat_on;
					end
				end
			end
			ST_TXDONE: begin
				if (!ce) begin
					nxt_state = ST_STBY;
					nxt_done  = 1'b0;
				end else if (!txs) begin
					nxt_state  = ST_RXSET;
					nxt_settle = 18'h00000;
					nxt_done   = 1'b0;
				end
			end
			default: begin
				nxt_state = ST_STBY;
			end
		endcase
		// new packet clears done, repeat sets it
		if (start_tx) begin
			nxt_state   = ST_TXRUN;
			nxt_tx_sh   = `RBM_PRE_PATTERN;
			nxt_tx_bits = `RBM_PRE_LAST;
			nxt_tx_pre  = 1'b1;
			nxt_tx_idx  = 6'h00;
			nxt_tx_sum  = 8'h00;
			nxt_done    = repeat_on;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff   <= ST_STBY;
			cfg_ff     <= `RBM_CFG_RST;
			mode_ff    <= `RBM_MODE_RST;
			rx_addr_ff <= `RBM_ADDR_RST;
			tx_addr_ff <= `RBM_ADDR_RST;
			tx_len_ff  <= 6'h00;
			settle_ff  <= 18'h00000;
			tx_sh_ff   <= 10'h000;
			tx_bits_ff <= 4'h0;
			tx_idx_ff  <= 6'h00;
			tx_pre_ff  <= 1'b0;
			tx_sum_ff  <= 8'h00;
			rx_sh_ff   <= 32'h0000_0000;
			rx_bits_ff <= 3'h0;
			rx_idx_ff  <= 6'h00;
			rx_plen_ff <= 6'h00;
			rx_len_ff  <= 6'h00;
			rd_ptr_ff  <= 6'h00;
			rx_sum_ff  <= 8'h00;
			am_ff      <= 1'b0;
			done_ff    <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			pa_level_ff            <= 2'h0;
			rx_low_power_ff        <= 1'b0;
			freq_code_ff           <= 14'h0000;
			carrier_sensed_flag_ff <= 1'b0;
			address_hit_flag_ff    <= 1'b0;
			packet_done_flag_ff    <= 1'b0;
		end else begin
			state_ff   <= nxt_state;
			cfg_ff     <= nxt_cfg;
			mode_ff    <= nxt_mode;
			rx_addr_ff <= nxt_rx_addr;
			tx_addr_ff <= nxt_tx_addr;
			tx_len_ff  <= nxt_tx_len;
			settle_ff  <= nxt_settle;
			tx_sh_ff   <= nxt_tx_sh;
			tx_bits_ff <= nxt_tx_bits;
			tx_idx_ff  <= nxt_tx_idx;
			tx_pre_ff  <= nxt_tx_pre;
			tx_sum_ff  <= nxt_tx_sum;
			rx_sh_ff   <= nxt_rx_sh;
			rx_bits_ff <= nxt_rx_bits;
			rx_idx_ff  <= nxt_rx_idx;
			rx_plen_ff <= nxt_rx_plen;
			rx_len_ff  <= nxt_rx_len;
			rd_ptr_ff  <= nxt_rd_ptr;
			rx_sum_ff  <= nxt_rx_sum;
			am_ff      <= nxt_am;
			done_ff    <= nxt_done;
			prdata_ff  <= nxt_prdata;
			pready_ff  <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			pa_level_ff <= cfg_ff[`RBM_CFG_PWR_MSB:`RBM_CFG_PWR_LSB];
			rx_low_power_ff <= cfg_ff[`RBM_CFG_LOWPWR_BIT] & (state_ff == ST_RXSET || state_ff == ST_RXHUNT ||
				state_ff == ST_RXPKT);
			freq_code_ff <= (`RBM_FREQ_BASE + {5'h00, cfg_ff[`RBM_CFG_CH_MSB:`RBM_CFG_CH_LSB]}) <<
				cfg_ff[`RBM_CFG_BAND_BIT];
			carrier_sensed_flag_ff <= rf_carrier_in & (state_ff == ST_RXHUNT || state_ff == ST_RXPKT);
			address_hit_flag_ff    <= nxt_am;
			packet_done_flag_ff    <= nxt_done;
		end
	end
endmodule // rbm_top
`default_nettype wire

// *** dv/rbm_top_sva.sv ***
// Port checks for the radio mode block
`timescale 1ns/1ps
`default_nettype none
module rbm_top_sva (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata_ff,
	input wire logic        pready_ff,
	input wire logic        pslverr_ff,
	// Radio and flags
	input wire logic        rf_carrier_in,
	input wire logic [1:0]  pa_level_ff,
	input wire logic [13:0] freq_code_ff,
	input wire logic        carrier_sensed_flag_ff
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic cfg_wr = psel && penable && pready_ff && pwrite && (paddr == 8'h00);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence
	a_apb_one_wait: assert property (s_setup ##1 s_access |-> !pready_ff ##1 pready_ff)
		else $error("ready not in second access cycle");
	a_ready_one_cycle: assert property (pready_ff |=> !pready_ff)
		else $error("ready longer than one cycle");
	a_err_by_addr: assert property (pready_ff |-> pslverr_ff == ((paddr > 8'h24) || (paddr[1:0] != 2'h0)))
		else $error("error response wrong for address");
	a_err_read_zero: assert property (pready_ff && pslverr_ff && !pwrite |-> prdata_ff == 32'h0)
		else $error("refused read data not zero");
	a_carrier_cause: assert property (carrier_sensed_flag_ff |-> $past(rf_carrier_in))
		else $error("carrier flag without carrier");
	a_carrier_drop: assert property (!rf_carrier_in |=> !carrier_sensed_flag_ff)
		else $error("carrier flag stays after carrier");
	a_freq_by_write: assert property ($changed(freq_code_ff) && $past(freq_code_ff) != 14'h0 |-> $past(cfg_wr, 2))
		else $error("frequency changed without config write");
	a_pa_by_write: assert property ($changed(pa_level_ff) |-> $past(cfg_wr) || $past(cfg_wr, 2))
		else $error("power level changed without config write");
endmodule // rbm_top_sva
bind rbm_top rbm_top_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
	.rf_carrier_in(rf_carrier_in), .pa_level_ff(pa_level_ff), .freq_code_ff(freq_code_ff),
	.carrier_sensed_flag_ff(carrier_sensed_flag_ff));
`default_nettype wire

// *** dv/rbm_peer_radio.sv ***
// Far radio: carrier level and Manchester chips toward the receiver
`timescale 1ns/1ps
`default_nettype none
`include "rbm_consts.vh"
module rbm_peer_radio (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Bench control
	input  wire logic carrier_on,
	// Radio lines
	output var logic  rf_rx_chip,
	output var logic  rf_carrier_in
);
	int   cnt;
	logic half;
	logic bit_v;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			half <= 1'b0;
			bit_v <= 1'b0;
			rf_rx_chip <= 1'b0;
			rf_carrier_in <= 1'b0;
		end else if (!carrier_on) begin
			rf_carrier_in <= 1'b0;
			rf_rx_chip <= ~rf_rx_chip;
		end else begin
			rf_carrier_in <= 1'b1;
			cnt <= (cnt == `RBM_CHIP_LAST) ? 0 : cnt + 1;
			if (cnt == `RBM_CHIP_LAST) begin
				half <= ~half;
				if (half)
					bit_v <= 1'($urandom);
				rf_rx_chip <= half ? ~bit_v : bit_v;
			end
		end
	end
endmodule // rbm_peer_radio
`default_nettype wire

// *** dv/rbm_top_tb.sv ***
// Self-checking bench for the radio mode block
`timescale 1ns/1ps
`default_nettype none
`include "rbm_consts.vh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; $display("ERROR %s exp %h got %h", n, e, g); end end
module rbm_top_tb;
	logic             pclk = 1'b0;
	logic             presetn = 1'b0;
	logic             psel = 1'b0;
	logic             penable = 1'b0;
	logic             pwrite = 1'b0;
	logic [7:0]       paddr = 8'h00;
	logic [31:0]      pwdata = 32'h0;
	logic             carrier_on = 1'b0;
	int               miscompares = 0;
	int               checks = 0;
	wire logic [31:0] prdata_ff;
	wire logic        pready_ff;
	wire logic        pslverr_ff;
	wire logic        rf_rx_chip;
	wire logic        rf_carrier_in;
	wire logic        rf_tx_chip;
	wire logic [1:0]  pa_level_ff;
	wire logic        rx_low_power_ff;
	wire logic [13:0] freq_code_ff;
	wire logic        carrier_sensed_flag_ff;
	wire logic        address_hit_flag_ff;
	wire logic        packet_done_flag_ff;
	rbm_top #(.SETTLE_CYC(18'h00014)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
		.pslverr_ff(pslverr_ff), .rf_rx_chip(rf_rx_chip), .rf_carrier_in(rf_carrier_in), .rf_tx_chip(rf_tx_chip),
		.pa_level_ff(pa_level_ff), .rx_low_power_ff(rx_low_power_ff), .freq_code_ff(freq_code_ff),
		.carrier_sensed_flag_ff(carrier_sensed_flag_ff), .address_hit_flag_ff(address_hit_flag_ff),
		.packet_done_flag_ff(packet_done_flag_ff));
	rbm_peer_radio u_peer (.pclk(pclk), .presetn(presetn), .carrier_on(carrier_on), .rf_rx_chip(rf_rx_chip),
		.rf_carrier_in(rf_carrier_in));
	initial begin
		forever #2.5 pclk = ~pclk;
	end
	task automatic results();
		if (miscompares == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	function automatic logic [13:0] exp_freq(input logic [8:0] ch, input logic bd);
		return (`RBM_FREQ_BASE + {5'h0, ch}) * (14'h0001 + {13'h0000, bd});
	endfunction
	function automatic logic [7:0] exp_dbm(input logic [1:0] p);
		case (p)
			2'h0: return 8'hf6;
			2'h1: return 8'hfe;
			2'h2: return 8'h06;
			default: return 8'h0a;
		endcase
	endfunction
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready_ff === 1'b1)
				break;
		end
		r = prdata_ff;
		e = pslverr_ff;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 16) begin
			miscompares++;
			results();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0, r, e);
	endtask
	task automatic gap(output int g);
		logic v;
		v = rf_tx_chip;
		// First gap may span three chips after start
		for (g = 1; g < 7000; g++) begin
			@(posedge pclk);
			if (rf_tx_chip !== v)
				break;
		end
		if (g == 7000) begin
			miscompares++;
			results();
		end
	endtask
	initial begin
		logic [31:0] r;
		logic        e;
		logic [8:0]  ch;
		logic        bd;
		logic [1:0]  pw;
		int          g;
		int          t;
		void'($urandom(48708));
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd(8'h00, r);
		`CHK("config", 32'h0000006c, r)
		`CHK("freq", 14'h10ec, freq_code_ff)
		rd(8'h1c, r);
		`CHK("dbm", 32'h000000f6, r)
		apb(1'b0, 8'h28, 32'h0, r, e);
		`CHK("unmapped", 33'h100000000, {e, r})
		// Channel, band and power sweep, corners first
		for (int k = 0; k < 10; k++) begin
			ch = (k == 0) ? 9'h000 : (k == 1) ? 9'h1ff : 9'($urandom);
			bd = (k == 0) ? 1'b0 : (k == 1) ? 1'b1 : 1'($urandom);
			pw = 2'(k);
			wr(8'h00, {18'h0, 1'b0, 1'b0, pw, bd, ch});
			rd(8'h1c, r);
			`CHK("freq", exp_freq(ch, bd), freq_code_ff)
			`CHK("pa", pw, pa_level_ff)
			`CHK("dbm", exp_dbm(pw), r[7:0])
		end
		wr(8'h00, 32'h0000106c);
		repeat (200) @(posedge pclk);
		rd(8'h00, r);
		`CHK("kept", 32'h0000106c, r)
		`CHK("lowpwr stby", 1'b0, rx_low_power_ff)
		wr(8'h04, 32'h1);
		rd(8'h0c, r);
		`CHK("settle", 3'h1, r[6:4])
		repeat (30) @(posedge pclk);
		rd(8'h0c, r);
		`CHK("hunt", 3'h2, r[6:4])
		`CHK("lowpwr rx", 1'b1, rx_low_power_ff)
		wr(8'h00, 32'h0);
		rd(8'h00, r);
		`CHK("cfg locked", 32'h0000106c, r)
		`CHK("no carrier", 1'b0, carrier_sensed_flag_ff)
		carrier_on <= 1'b1;
		repeat (5) @(posedge pclk);
		`CHK("carrier", 1'b1, carrier_sensed_flag_ff)
		carrier_on <= 1'b0;
		repeat (5) @(posedge pclk);
		`CHK("idle", 1'b0, carrier_sensed_flag_ff)
		carrier_on <= 1'b1;
		wr(8'h04, 32'h0);
		rd(8'h0c, r);
		`CHK("leave", 3'h0, r[6:4])
		`CHK("hit off", 1'b0, address_hit_flag_ff)
		`CHK("stby cd", 1'b0, carrier_sensed_flag_ff)
		wr(8'h10, 32'h0000005a);
		rd(8'h10, r);
		`CHK("tx count", 6'h01, r[5:0])
		wr(8'h00, 32'h0000306c);
		wr(8'h04, 32'h3);
		repeat (10) @(posedge pclk);
		rd(8'h0c, r);
		`CHK("tx run", 3'h4, r[6:4])
		`CHK("rep done", 1'b1, packet_done_flag_ff)
		`CHK("lowpwr tx", 1'b0, rx_low_power_ff)
		wr(8'h04, 32'h0);
		t = 0;
		for (int k = 0; k < 6; k++) begin
			gap(g);
			t += g;
			if (k > 0)
				`CHK("chip gap", 1'b1, (g == 2000) || (g == 4000))
		end
		repeat (42000 - t) @(posedge pclk);
		rd(8'h0c, r);
		`CHK("still tx", 3'h4, r[6:4])
		`CHK("pulse end", 1'b0, packet_done_flag_ff)
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd(8'h00, r);
		`CHK("cfg reset", 32'h0000006c, r)
		`CHK("tx idle", 1'b0, rf_tx_chip)
		results();
	end
endmodule // rbm_top_tb
`default_nettype wire
